// >>> src/hsf_map.svh
/*
  register offsets, field positions, reset values and codes of the
  host slave fifo block.
  assumes: included once per compile unit by bare name.
*/
// Notes on behaviour
// - 128-byte array split into two circular channels.
// - host and cpu access array in same cycle.
// - host write latches byte; command address sets flag.
// - command at input head interrupts the cpu.
// - wrong-type cpu read gives FF, pointer kept.
// - input pointers writable only while frozen.
// - input write pointer wraps at boundary to zero.
// - first byte into empty channel fills port.
// - host write to full input dropped, overrun raised.
// - cpu read of empty input gives FF, underrun.
// - cpu read advances pointer, next entry preloaded.
// - input request from free space until full.
// - outbound command port sets flag, data clears.
// - output head preloaded; command head flags host.
// - outbound port writes advance write pointer only.
// - output write pointer wraps to boundary value.
// - wrong-type host read gives FF, pointer kept.
// - output request at threshold plus one, until empty.
// - flush mode command write raises output request.
// - immediate registers bypass fifo with status flags.
// - parties poll status before immediate transfers.
// - every entry nine bits with command flag.
// - boundary resets 40H; write resets all pointers.
// - freeze active when freeze bit reads zero.
`ifndef HSF_MAP_SVH
`define HSF_MAP_SVH
`define HSF_A_IN_DATA   8'h00
`define HSF_A_IN_CMD    8'h04
`define HSF_A_OUT_DATA  8'h08
`define HSF_A_OUT_CMD   8'h0C
`define HSF_A_IN_RD     8'h10
`define HSF_A_IN_WR     8'h14
`define HSF_A_OUT_RD    8'h18
`define HSF_A_OUT_WR    8'h1C
`define HSF_A_CBP       8'h20
`define HSF_A_IN_THR    8'h24
`define HSF_A_OUT_THR   8'h28
`define HSF_A_CTRL      8'h2C
`define HSF_A_STAT      8'h30
`define HSF_A_HOST_IMMEDIATE_INBOX      8'h34
`define HSF_A_HOST_IMMEDIATE_OUTBOX     8'h38
`define HSF_C_FRZ       0
`define HSF_C_FLUSH     1
`define HSF_C_INIE      2
`define HSF_C_IMIE      3
`define HSF_H_DATA      2'h0
`define HSF_H_CMD       2'h1
`define HSF_H_IMM       2'h2
`define HSF_H_STAT      2'h3
`define HSF_RST_CBP     7'h40
`define HSF_BAD         8'hFF
`define HSF_TOP_ADDR    7'h7F
`define HSF_DEPTH       8'h80
`define HSF_OKAY        2'h0
`define HSF_SLVERR      2'h2
`endif

// >>> src/hsf_pkg.sv
/*
  types of the host slave fifo block.
  assumes: nothing beyond a systemverilog compiler.
*/
package hsf_pkg;
  typedef logic [7:0] hsf_byte_t;
  typedef struct packed {
    logic [127:0][8:0] mem;
    logic [6:0]        in_rd, in_wr, out_rd, out_wr, channel_boundary_pointer, ithr, outbound_threshold_reg;
    logic              in_full, out_full, freeze_control_bit, flush, in_ie, imm_ie;
    logic [2:0]        hcon;
    logic              in_req, out_req, underrun, out_ovr, host_ovr;
    logic [7:0]        host_immediate_inbox, host_immediate_outbox, hdout, wdata, awaddr;
    logic              host_immediate_inbox_full, host_immediate_outbox_full;
    logic [8:0]        in_head, out_head, out_last;
    logic              in_ok, out_ok, wr_q, rd_q, wen;
    logic              awready, wready, aw_got, w_got, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp;
    logic [31:0]       rdata;
    logic              cpu_int, host_int;
  } hsf_state_t;
endpackage : hsf_pkg

// >>> src/hsf_top.sv
/*
  shared two-channel fifo between a parallel host bus and the internal
  cpu, which reaches its registers over axi4-lite.
  assumes: host strobes and bus are synchronous to sys_clk_in; strobes
  active low; one host access per strobe.
*/
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "hsf_map.svh"
module hsf_top (
  input  wire logic           sys_clk_in,
  input  wire logic           reset_n_in,
  input  wire logic [7:0]     s_axi_awaddr_in,
  input  wire logic           s_axi_awvalid_in,
  output logic                s_axi_awready_out,
  input  wire logic [31:0]    s_axi_wdata_in,
  input  wire logic [3:0]     s_axi_wstrb_in,
  input  wire logic           s_axi_wvalid_in,
  output logic                s_axi_wready_out,
  output logic [1:0]          s_axi_bresp_out,
  output logic                s_axi_bvalid_out,
  input  wire logic           s_axi_bready_in,
  input  wire logic [7:0]     s_axi_araddr_in,
  input  wire logic           s_axi_arvalid_in,
  output logic                s_axi_arready_out,
  output logic [31:0]         s_axi_rdata_out,
  output logic [1:0]          s_axi_rresp_out,
  output logic                s_axi_rvalid_out,
  input  wire logic           s_axi_rready_in,
  input  wire logic           host_wr_n_in,
  input  wire logic           host_rd_n_in,
  input  wire logic [1:0]     host_addr_in,
  input  wire hsf_pkg::hsf_byte_t host_data_in,
  output hsf_pkg::hsf_byte_t  host_data_out,
  output logic                host_in_req_out,
  output logic                host_out_req_out,
  output logic                host_intr_out,
  output logic                cpu_intr_out
);
  import hsf_pkg::*;

  hsf_state_t s_r;
  hsf_state_t s_nxt;
  logic [7:0] isz, osz, icnt, ocnt, rdb, cpu_side_status_reg, host_side_status_reg;
  logic       hw, hr, ex_wr, ar_take, flush_hit, want;
  logic [1:0] resp;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [6:0] in_inc(input logic [6:0] p,
                                        input logic [7:0] sz);
    logic [7:0] q;
    q = {1'b0, p} + 8'h01;
    return (q >= sz) ? 7'h00 : q[6:0];
  endfunction : in_inc

  function automatic logic [6:0] out_inc(input logic [6:0] p,
                                         input logic [6:0] base);
    return (p == `HSF_TOP_ADDR) ? base : p + 7'h01;
  endfunction : out_inc

  // occupancy from pointers; full flag breaks the rd==wr tie
  function automatic logic [7:0] fcnt(input logic [6:0] rd,
                                      input logic [6:0] wr,
                                      input logic       full,
                                      input logic [7:0] sz);
    if (full)
      return sz;
    else if (wr >= rd)
      return {1'b0, wr - rd};
    else
      return sz - {1'b0, rd - wr};
  endfunction : fcnt

  assign ex_wr   = s_r.aw_got && s_r.w_got && !s_r.bvalid;
  assign ar_take = s_axi_arvalid_in && s_r.arready;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_nxt     = s_r;
    flush_hit = 1'b0;
    rdb       = 8'h00;
    resp      = `HSF_OKAY;
    want      = 1'b0;
    // a zero boundary still leaves the input one entry
    isz   = (s_r.channel_boundary_pointer == 7'h00) ? 8'h01 : {1'b0, s_r.channel_boundary_pointer};
    osz   = `HSF_DEPTH - {1'b0, s_r.channel_boundary_pointer};
    hw    = !s_r.wr_q && host_wr_n_in;
    hr    = s_r.rd_q && !host_rd_n_in;
    cpu_side_status_reg = {s_r.out_ovr, s_r.host_immediate_outbox_full, !s_r.freeze_control_bit, s_r.out_req,
             s_r.underrun, s_r.host_immediate_inbox_full, s_r.in_ok & s_r.in_head[8],
             s_r.in_req};
    host_side_status_reg = {s_r.in_req, s_r.out_req, s_r.host_immediate_outbox_full, s_r.host_immediate_inbox_full,
             s_r.out_ok & s_r.out_head[8], s_r.host_ovr, 2'b00};
    s_nxt.wr_q = host_wr_n_in;
    s_nxt.rd_q = host_rd_n_in;

    // host read at the falling strobe edge, from the preloaded latch
    if (hr) begin
      case (host_addr_in)
        `HSF_H_DATA, `HSF_H_CMD: begin
          want = (host_addr_in == `HSF_H_CMD);
          if (!s_r.out_ok || s_r.out_head[8] != want) begin
            s_nxt.hdout = `HSF_BAD;
          end else begin
            s_nxt.hdout    = s_r.out_head[7:0];
            s_nxt.out_rd   = out_inc(s_r.out_rd, s_r.channel_boundary_pointer);
            s_nxt.out_full = 1'b0;
          end
        end
        `HSF_H_IMM: begin
          s_nxt.hdout      = s_r.host_immediate_outbox;
          s_nxt.host_immediate_outbox_full = 1'b0;
        end
        default: begin
          s_nxt.hdout    = host_side_status_reg;
          s_nxt.host_ovr = 1'b0;
        end
      endcase
    end

    // axi read channel
    if (s_r.rvalid && s_axi_rready_in)
      s_nxt.rvalid = 1'b0;
    if (ar_take) begin
      case (s_axi_araddr_in)
        `HSF_A_IN_DATA, `HSF_A_IN_CMD: begin
          want = (s_axi_araddr_in == `HSF_A_IN_CMD);
          if (!s_r.in_ok) begin
            rdb            = `HSF_BAD;
            s_nxt.underrun = 1'b1;
          end else if (s_r.in_head[8] != want) begin
            rdb = `HSF_BAD;
          end else begin
            rdb           = s_r.in_head[7:0];
            s_nxt.in_rd   = in_inc(s_r.in_rd, isz);
            s_nxt.in_full = 1'b0;
          end
        end
        `HSF_A_OUT_DATA, `HSF_A_OUT_CMD: rdb = s_r.out_last[7:0];
        `HSF_A_IN_RD:   rdb = {1'b0, s_r.in_rd};
        `HSF_A_IN_WR:   rdb = {1'b0, s_r.in_wr};
        `HSF_A_OUT_RD:  rdb = {1'b0, s_r.out_rd};
        `HSF_A_OUT_WR:  rdb = {1'b0, s_r.out_wr};
        `HSF_A_CBP:     rdb = {1'b0, s_r.channel_boundary_pointer};
        `HSF_A_IN_THR:  rdb = {1'b0, s_r.ithr};
        `HSF_A_OUT_THR: rdb = {s_r.out_req, s_r.outbound_threshold_reg};
        `HSF_A_CTRL:    rdb = {4'h0, s_r.imm_ie, s_r.in_ie, s_r.flush, s_r.freeze_control_bit};
        `HSF_A_STAT: begin
          rdb            = cpu_side_status_reg;
          s_nxt.underrun = 1'b0;
          s_nxt.out_ovr  = 1'b0;
        end
        `HSF_A_HOST_IMMEDIATE_INBOX: begin
          rdb             = s_r.host_immediate_inbox;
          s_nxt.host_immediate_inbox_full = 1'b0;
        end
        `HSF_A_HOST_IMMEDIATE_OUTBOX:   rdb = s_r.host_immediate_outbox;
        default:        resp = `HSF_SLVERR;
      endcase
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = {24'h000000, rdb};
      s_nxt.rresp  = resp;
    end

    // axi write channel: address and data taken in either order
    if (s_r.bvalid && s_axi_bready_in)
      s_nxt.bvalid = 1'b0;
    if (s_axi_awvalid_in && s_r.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_r.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata_in[7:0];
      s_nxt.wen   = s_axi_wstrb_in[0];
    end
    if (ex_wr) begin
      resp = `HSF_OKAY;
      case (s_r.awaddr)
        `HSF_A_OUT_DATA, `HSF_A_OUT_CMD: if (s_r.wen) begin
          want = (s_r.awaddr == `HSF_A_OUT_CMD);
          s_nxt.out_last = {want, s_r.wdata};
          if (s_nxt.out_full) begin
            s_nxt.out_ovr = 1'b1;
          end else begin
            s_nxt.mem[s_nxt.out_wr] = {want, s_r.wdata};
            s_nxt.out_wr = out_inc(s_nxt.out_wr, s_r.channel_boundary_pointer);
            s_nxt.out_full = (s_nxt.out_wr == s_nxt.out_rd);
            flush_hit = want && s_r.flush;
          end
        end
        `HSF_A_IN_RD: if (s_r.wen && !s_r.freeze_control_bit) begin
          s_nxt.in_rd   = s_r.wdata[6:0];
          s_nxt.in_full = 1'b0;
        end
        `HSF_A_IN_WR: if (s_r.wen && !s_r.freeze_control_bit) begin
          s_nxt.in_wr   = s_r.wdata[6:0];
          s_nxt.in_full = 1'b0;
        end
        `HSF_A_OUT_RD: if (s_r.wen && !s_r.freeze_control_bit) begin
          s_nxt.out_rd   = s_r.wdata[6:0];
          s_nxt.out_full = 1'b0;
        end
        `HSF_A_OUT_WR: if (s_r.wen && !s_r.freeze_control_bit) begin
          s_nxt.out_wr   = s_r.wdata[6:0];
          s_nxt.out_full = 1'b0;
        end
        `HSF_A_CBP: if (s_r.wen && !s_r.freeze_control_bit) begin
          s_nxt.channel_boundary_pointer      = s_r.wdata[6:0];
          s_nxt.in_rd    = 7'h00;
          s_nxt.in_wr    = 7'h00;
          s_nxt.out_rd   = s_r.wdata[6:0];
          s_nxt.out_wr   = s_r.wdata[6:0];
          s_nxt.in_full  = 1'b0;
          s_nxt.out_full = 1'b0;
        end
        `HSF_A_IN_THR:  if (s_r.wen) s_nxt.ithr = s_r.wdata[6:0];
        `HSF_A_OUT_THR: if (s_r.wen) s_nxt.outbound_threshold_reg = s_r.wdata[6:0];
        `HSF_A_CTRL: if (s_r.wen) begin
          s_nxt.freeze_control_bit    = s_r.wdata[`HSF_C_FRZ];
          s_nxt.flush  = s_r.wdata[`HSF_C_FLUSH];
          s_nxt.in_ie  = s_r.wdata[`HSF_C_INIE];
          s_nxt.imm_ie = s_r.wdata[`HSF_C_IMIE];
        end
        `HSF_A_HOST_IMMEDIATE_OUTBOX: if (s_r.wen) begin
          s_nxt.host_immediate_outbox      = s_r.wdata;
          s_nxt.host_immediate_outbox_full = 1'b1;
        end
        `HSF_A_IN_DATA, `HSF_A_IN_CMD, `HSF_A_STAT, `HSF_A_HOST_IMMEDIATE_INBOX: ;
        default: resp = `HSF_SLVERR;
      endcase
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = resp;
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
    end

    // host write at the rising strobe edge, same cycle as cpu traffic
    if (hw) begin
      case (host_addr_in)
        `HSF_H_DATA, `HSF_H_CMD: begin
          if (s_nxt.in_full) begin
            s_nxt.host_ovr = 1'b1;
          end else begin
            s_nxt.mem[s_nxt.in_wr] = {host_addr_in == `HSF_H_CMD,
                                      host_data_in};
            s_nxt.in_wr   = in_inc(s_nxt.in_wr, isz);
            s_nxt.in_full = (s_nxt.in_wr == s_nxt.in_rd);
          end
        end
        `HSF_H_IMM: begin
          s_nxt.host_immediate_inbox      = host_data_in;
          s_nxt.host_immediate_inbox_full = 1'b1;
        end
        default: s_nxt.hcon = host_data_in[2:0];
      endcase
    end

    // port latches track the channel heads
    s_nxt.in_ok    = !(s_nxt.in_rd == s_nxt.in_wr && !s_nxt.in_full);
    s_nxt.in_head  = s_nxt.mem[s_nxt.in_rd];
    s_nxt.out_ok   = !(s_nxt.out_rd == s_nxt.out_wr && !s_nxt.out_full);
    s_nxt.out_head = s_nxt.mem[s_nxt.out_rd];

    icnt = fcnt(s_nxt.in_rd, s_nxt.in_wr, s_nxt.in_full, isz);
    ocnt = fcnt(s_nxt.out_rd, s_nxt.out_wr, s_nxt.out_full, osz);
    if (s_nxt.in_full)
      s_nxt.in_req = 1'b0;
    else if (isz - icnt >= {1'b0, s_nxt.channel_boundary_pointer} - {1'b0, s_nxt.ithr})
      s_nxt.in_req = 1'b1;
    if (!s_nxt.out_ok)
      s_nxt.out_req = 1'b0;
    else if (ocnt >= {1'b0, s_nxt.outbound_threshold_reg} + 8'h01 || flush_hit)
      s_nxt.out_req = 1'b1;

    s_nxt.cpu_int  = (s_nxt.in_ie & ((s_nxt.in_ok & s_nxt.in_head[8]) |
                     s_nxt.underrun)) | (s_nxt.imm_ie & s_nxt.host_immediate_inbox_full);
    s_nxt.host_int = (s_nxt.hcon[0] & s_nxt.host_ovr) |
                     (s_nxt.hcon[1] & s_nxt.out_ok & s_nxt.out_head[8]) |
                     (s_nxt.hcon[2] & s_nxt.host_immediate_outbox_full);

    s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid;
    s_nxt.arready = !s_nxt.rvalid;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_r        <= '0;
      s_r.channel_boundary_pointer    <= `HSF_RST_CBP;
      s_r.out_rd <= `HSF_RST_CBP;
      s_r.out_wr <= `HSF_RST_CBP;
      s_r.wr_q   <= 1'b1;
      s_r.rd_q   <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready_out = s_r.awready;
  assign s_axi_wready_out  = s_r.wready;
  assign s_axi_bresp_out   = s_r.bresp;
  assign s_axi_bvalid_out  = s_r.bvalid;
  assign s_axi_arready_out = s_r.arready;
  assign s_axi_rdata_out   = s_r.rdata;
  assign s_axi_rresp_out   = s_r.rresp;
  assign s_axi_rvalid_out  = s_r.rvalid;
  assign host_data_out     = s_r.hdout;
  assign host_in_req_out   = s_r.in_req;
  assign host_out_req_out  = s_r.out_req;
  assign host_intr_out     = s_r.host_int;
  assign cpu_intr_out      = s_r.cpu_int;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  // pointer guards leave out same-cycle register writes and host strobes, which may move them
  in_wrong_type_a: assert property (
    ar_take && s_axi_araddr_in == `HSF_A_IN_DATA && s_r.in_ok && s_r.in_head[8] && !ex_wr
    |=> s_r.rdata[7:0] == `HSF_BAD && s_r.in_rd == $past(s_r.in_rd))
    else $error("wrong-type input read moved pointer");
  underrun_flag_a: assert property (
    ar_take && s_axi_araddr_in == `HSF_A_IN_CMD && !s_r.in_ok
    |=> s_r.underrun && s_r.rdata[7:0] == `HSF_BAD)
    else $error("empty input read without underrun");
  ptr_lock_a: assert property (
    ex_wr && s_r.awaddr == `HSF_A_IN_WR && s_r.freeze_control_bit && !hw
    |=> s_r.in_wr == $past(s_r.in_wr))
    else $error("input pointer written outside freeze");
  in_wrap_a: assert property (
    hw && host_addr_in == `HSF_H_DATA && !s_r.in_full && !ex_wr &&
    {1'b0, s_r.in_wr} == isz - 8'h01 |=> s_r.in_wr == 7'h00)
    else $error("input write pointer did not wrap");
  out_wrap_a: assert property (
    ex_wr && s_r.wen && s_r.awaddr == `HSF_A_OUT_DATA && !s_r.out_full &&
    !hr && s_r.out_wr == `HSF_TOP_ADDR |=> s_r.out_wr == s_r.channel_boundary_pointer)
    else $error("output write pointer did not wrap to boundary");
  out_req_hold_a: assert property (
    s_r.out_req ##1 !s_r.out_req |-> !s_r.out_ok)
    else $error("output request dropped before empty");
  in_req_hold_a: assert property (
    s_r.in_req ##1 !s_r.in_req |-> s_r.in_full)
    else $error("input request dropped before full");
  flush_req_a: assert property (
    ex_wr && s_r.wen && s_r.awaddr == `HSF_A_OUT_CMD && s_r.flush &&
    !s_r.out_full && !hr |=> s_r.out_req)
    else $error("flush command did not raise request");
  cbp_reload_a: assert property (
    ex_wr && s_r.wen && s_r.awaddr == `HSF_A_CBP && !s_r.freeze_control_bit && !hw && !hr
    |=> s_r.channel_boundary_pointer == $past(s_r.wdata[6:0]) && s_r.in_wr == 7'h00 && s_r.in_rd == 7'h00 &&
        s_r.out_rd == s_r.channel_boundary_pointer && s_r.out_wr == s_r.channel_boundary_pointer)
    else $error("boundary write did not reset pointers");
  out_wrong_type_a: assert property (
    hr && host_addr_in == `HSF_H_DATA && s_r.out_ok && s_r.out_head[8] && !ex_wr
    |=> s_r.hdout == `HSF_BAD && s_r.out_rd == $past(s_r.out_rd))
    else $error("wrong-type host read moved pointer");
endmodule : hsf_top

// >>> sim/hsf_host_model.sv
/*
  host cpu model on the parallel slave bus: byte writes and reads by
  active-low strobes.
  assumes: strobes held two cycles each way so the fifo sees each edge.
*/
`timescale 1ns/1ps
module hsf_host_model (
  input  wire logic               clk_in,
  output logic                    wr_n_out,
  output logic                    rd_n_out,
  output logic [1:0]              addr_out,
  output hsf_pkg::hsf_byte_t      data_out,
  input  wire hsf_pkg::hsf_byte_t data_in
);
  import hsf_pkg::*;
  initial begin
    wr_n_out = 1'b1;
    rd_n_out = 1'b1;
    addr_out = 2'h0;
    data_out = 8'h5A;
  end
  // ****************
  // strobe cycles
  // ****************
  // byte is latched on the rising strobe; the address picks the flag
  task automatic wr(input logic [1:0] a, input hsf_byte_t d);
    @(posedge clk_in);
    addr_out <= a;
    data_out <= d;
    wr_n_out <= 1'b0;
    repeat (2) @(posedge clk_in);
    wr_n_out <= 1'b1;
    repeat (2) @(posedge clk_in);
    data_out <= ~d; // bus let go: never leave the old byte standing
    @(posedge clk_in);
  endtask : wr
  task automatic rd(input logic [1:0] a, output hsf_byte_t d);
    @(posedge clk_in);
    addr_out <= a;
    rd_n_out <= 1'b0;
    repeat (2) @(posedge clk_in);
    d = data_in;
    rd_n_out <= 1'b1;
    repeat (2) @(posedge clk_in);
  endtask : rd
endmodule : hsf_host_model

// >>> sim/host_slave_fifo_interface_tb_top.sv
/*
  self-checking bench: axi4-lite register tasks on the cpu side, host
  model on the slave bus.
  assumes: design outputs are registered, sampled just after an edge.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module host_slave_fifo_interface_tb_top;
  import hsf_pkg::*;
  logic        sys_clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic [7:0]  awaddr, araddr, i;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, haddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, wr_n, rd_n;
  logic        in_req, out_req, hintr, cintr;
  hsf_byte_t   hdin, hdout;
  int          err_total = 0;
  int          samples_checked = 0;
  always #2 sys_clk_in = ~sys_clk_in;
  hsf_top DUT (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .host_wr_n_in(wr_n),
    .host_rd_n_in(rd_n), .host_addr_in(haddr), .host_data_in(hdin),
    .host_data_out(hdout), .host_in_req_out(in_req), .host_out_req_out(out_req),
    .host_intr_out(hintr), .cpu_intr_out(cintr));
  hsf_host_model HOST (.clk_in(sys_clk_in), .wr_n_out(wr_n), .rd_n_out(rd_n),
    .addr_out(haddr), .data_out(hdin), .data_in(hdout));
  // ****************
  // bus tasks
  // ****************
  task automatic idle;
    repeat (2) @(posedge sys_clk_in);
  endtask : idle
  task automatic axi_wr(input logic [7:0] a, input hsf_byte_t d, input logic [1:0] er = 2'h0);
    logic ga;
    logic gw;
    ga = 1'b0;
    gw = 1'b0;
    @(posedge sys_clk_in);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ga && gw)) begin
      @(posedge sys_clk_in);
      ga = ga || awready;
      gw = gw || wready;
      awvalid <= !ga;
      wvalid <= !gw;
    end
    do @(posedge sys_clk_in); while (!bvalid);
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask : axi_wr
  task automatic rchk(input logic [7:0] a, input hsf_byte_t e, input logic [1:0] er = 2'h0);
    @(posedge sys_clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk_in); while (!arready);
    arvalid <= 1'b0;
    do @(posedge sys_clk_in); while (!rvalid);
    rready <= 1'b0;
    `CHK(rresp, er)
    `CHK(rdata, {24'h0, e})
  endtask : rchk
  task automatic hchk(input logic [1:0] a, input hsf_byte_t e);
    hsf_byte_t d;
    HOST.rd(a, d);
    `CHK(d, e)
  endtask : hchk
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  // ****************
  // tests
  // ****************
  initial begin
    #100000;
    err_total++;
    complete_run;
  end
  initial begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (2) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    idle;
    `CHK(in_req, 1'b1)
    rchk(8'h20, 8'h40);
    rchk(8'h1C, 8'h40);
    rchk(8'h10, 8'h00);
    axi_wr(8'h2C, 8'h01);
    axi_wr(8'h14, 8'h05);
    rchk(8'h14, 8'h00);
    axi_wr(8'h2C, 8'h00);
    axi_wr(8'h14, 8'h02);
    rchk(8'h14, 8'h02);
    axi_wr(8'h20, 8'h04);
    rchk(8'h14, 8'h00);
    rchk(8'h18, 8'h04);
    axi_wr(8'h24, 8'h01);
    HOST.wr(2'h3, 8'h01);
    for (i = 0; i < 4; i++) begin
      HOST.wr({1'b0, i == 1}, 8'h10 + i);
      `CHK(in_req, i < 3)
    end
    rchk(8'h14, 8'h00);
    HOST.wr(2'h0, 8'hEE);
    `CHK(hintr, 1'b1)
    hchk(2'h3, 8'h04);
    axi_wr(8'h2C, 8'h04);
    for (i = 0; i < 4; i++) begin
      rchk(i == 1 ? 8'h00 : 8'h04, 8'hFF);
      `CHK(cintr, i == 1)
      rchk(i == 1 ? 8'h04 : 8'h00, 8'h10 + i);
      `CHK(in_req, i >= 2)
    end
    rchk(8'h00, 8'hFF);
    `CHK(cintr, 1'b1)
    rchk(8'h30, 8'h29);
    // output channel shrunk to four places so the wrap is reached
    axi_wr(8'h20, 8'h7C);
    axi_wr(8'h28, 8'h02);
    HOST.wr(2'h3, 8'h06);
    fork
      HOST.wr(2'h0, 8'h55);
      axi_wr(8'h08, 8'hA0);
    join
    for (i = 1; i < 4; i++) begin
      idle;
      `CHK(out_req, i == 3)
      axi_wr(8'h08, 8'hA0 + i);
    end
    rchk(8'h1C, 8'h7C);
    axi_wr(8'h08, 8'hA3);
    rchk(8'h30, 8'hB1);
    rchk(8'h08, 8'hA3);
    rchk(8'h1C, 8'h7C);
    rchk(8'h00, 8'h55);
    hchk(2'h1, 8'hFF);
    for (i = 0; i < 4; i++) begin
      `CHK(out_req, 1'b1)
      hchk(2'h0, 8'hA0 + i);
    end
    `CHK(out_req, 1'b0)
    axi_wr(8'h2C, 8'h02);
    axi_wr(8'h0C, 8'h5C);
    idle;
    `CHK(out_req, 1'b1)
    rchk(8'h28, 8'h82);
    `CHK(hintr, 1'b1)
    hchk(2'h3, 8'hC8);
    hchk(2'h0, 8'hFF);
    hchk(2'h1, 8'h5C);
    `CHK(hintr, 1'b0)
    axi_wr(8'h38, 8'h3C);
    idle;
    `CHK(hintr, 1'b1)
    hchk(2'h3, 8'hA0);
    hchk(2'h2, 8'h3C);
    `CHK(hintr, 1'b0)
    axi_wr(8'h2C, 8'h08);
    rchk(8'h2C, 8'h08);
    HOST.wr(2'h2, 8'h4D);
    `CHK(cintr, 1'b1)
    rchk(8'h30, 8'h25);
    rchk(8'h34, 8'h4D);
    idle;
    `CHK(cintr, 1'b0)
    // unmapped offsets answer with an error and change nothing
    rchk(8'h40, 8'h00, 2'h2);
    axi_wr(8'h3C, 8'h00, 2'h2);
    complete_run;
  end
endmodule : host_slave_fifo_interface_tb_top
